// [bus_state_pkg.sv]
// Package of constants and carrier types for the bus state unit
package bus_state_pkg;
  localparam int ADDR_W = 25;
  localparam int SPACE_N = 5;
  localparam int DRAM_SPACE = 3;
  localparam int SDRAM_SPACE = 2;
  localparam int LINE_WORDS = 4;
  localparam logic [15:0] WRITE_KEY = 16'hA55A;
  localparam logic [3:0] WAIT_RESET = 4'h3;
  // Stored word matches the live reset setup: ordinary, 32-bit, reset waits
  localparam logic [15:0] CFG_RESET = {4'h0, WAIT_RESET, 8'h08};
  localparam int PRECHARGE_NS = 80;
  localparam int CLK_NS = 40;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CACHE_THRU_BIT = 29;

  typedef enum logic [1:0] {MEM_ORDINARY, MEM_DRAM, MEM_SDRAM, MEM_BURST}
    mem_type_t;
  typedef enum logic [1:0] {WIDTH_8, WIDTH_16, WIDTH_32, WIDTH_RSV} width_t;
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} size_t;

  typedef struct packed {
    mem_type_t mem_type;
    width_t width;
    logic [3:0] waits;
  } space_cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    size_t size;
    logic [31:0] wdata;
    logic cached;
  } cpu_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic data_oe_n;
    logic start_n;
    logic [SPACE_N-1:0] sel_n;
    logic rd_wr;
    logic rd_n;
    logic ras_n;
    logic cas_n;
    logic bus_oe_n;
  } ext_bus_t;
endpackage : bus_state_pkg

// [cfg_store.sv]
// Small register store holding one 16-bit configuration word per index
`timescale 1ns/1ns
module cfg_store #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_idx_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [AW-1:0] rd_idx_in,
  output logic [15:0] rd_data_out
);
  logic [15:0] mem_q [DEPTH];
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= bus_state_pkg::CFG_RESET;
      rd_data_out <= 16'h0000;
    end
    else
    begin
      if (wr_en_in)
        mem_q[wr_idx_in] <= wr_data_in;
      rd_data_out <= mem_q[rd_idx_in];
    end
  end
endmodule : cfg_store

// [bus_state_unit.sv]
// External bus state controller: spaces, strobes, refresh and release
`timescale 1ns/1ns
module bus_state_unit #(
  parameter int SPACE_N = bus_state_pkg::SPACE_N,
  parameter int REFRESH_DIV = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire bus_state_pkg::cpu_req_t cpu_req_in,
  output logic cpu_ack_out,
  output logic [31:0] cpu_rdata_out,
  input wire logic cfg_wr_in,
  input wire logic [2:0] cfg_idx_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic cfg_long_in,
  output logic [31:0] cfg_rdata_out,
  input wire logic write_back_in,
  output logic write_buffer_dirty_out,
  input wire logic self_refresh_in,
  input wire logic [2:0] refresh_burst_in,
  input wire logic [7:0] refresh_const_in,
  output logic compare_match_irq_out,
  input wire logic [31:0] external_data_in,
  input wire logic wait_n_in,
  input wire logic release_request_in,
  output logic grant_out,
  output bus_state_pkg::ext_bus_t ext_bus_out,
  output logic cke_out,
  output logic [3:0] byte_strobe_n_out
);
  typedef enum {ST_IDLE, ST_ADDR, ST_WAIT, ST_END, ST_PRECHARGE, ST_REFRESH,
    ST_RELEASED} state_t;
  state_t state_q, state_d;

  logic [2:0] wait_sync_q;
  logic [2:0] rel_sync_q;
  logic wait_act, release_act;
  assign wait_act = !wait_sync_q[1] && !wait_sync_q[2];
  assign release_act = rel_sync_q[1] && rel_sync_q[2];

  // Space configuration words: [5:4] type, [3:2] width, [1:0] unused
  logic [15:0] cfg_rd;
  logic cfg_take;
  // Long writes need the key to reshape the bus; short writes (cfg_long_in low) are taken without it
  assign cfg_take = cfg_wr_in && (!cfg_long_in ||
    cfg_wdata_in[31:16] == bus_state_pkg::WRITE_KEY);
  cfg_store #(.DEPTH(8), .AW(3)) u_cfg (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(cfg_take),
    .wr_idx_in(cfg_idx_in),
    .wr_data_in(cfg_wdata_in[15:0]),
    .rd_idx_in(cfg_idx_in),
    .rd_data_out(cfg_rd)
  );

  bus_state_pkg::space_cfg_t cfg_q [SPACE_N];
  genvar g;
  generate
    for (g = 0; g < SPACE_N; g++)
    begin : g_cfg
      always_ff @(posedge sys_clk_in)
      begin
        if (!rst_n_in)
        begin
          cfg_q[g].mem_type <= bus_state_pkg::MEM_ORDINARY;
          cfg_q[g].width <= bus_state_pkg::WIDTH_32;
          cfg_q[g].waits <= bus_state_pkg::WAIT_RESET;
        end
        else if (cfg_take && cfg_idx_in == 3'(g))
        begin
          cfg_q[g].mem_type <= bus_state_pkg::mem_type_t'(cfg_wdata_in[5:4]);
          cfg_q[g].width <= bus_state_pkg::width_t'(cfg_wdata_in[3:2]);
          cfg_q[g].waits <= cfg_wdata_in[11:8];
        end
      end
    end
  endgenerate

  // Request capture
  bus_state_pkg::cpu_req_t req_q;
  logic [2:0] space_w;
  logic [2:0] space_q;
  assign space_w = cpu_req_in.addr[27:25];
  logic space_ok;
  assign space_ok = space_w < 3'(SPACE_N);
  logic through_w;
  assign through_w = cpu_req_in.addr[bus_state_pkg::CACHE_THRU_BIT];
  bus_state_pkg::space_cfg_t cur_cfg;
  assign cur_cfg = cfg_q[space_q];
  logic is_dram, is_sdram;
  assign is_dram = cur_cfg.mem_type == bus_state_pkg::MEM_DRAM;
  assign is_sdram = cur_cfg.mem_type == bus_state_pkg::MEM_SDRAM;

  // Line fill: cached read miss issues four longword beats
  logic fill_q;
  logic [1:0] beat_q;
  logic [3:0] wait_cnt_q;
  logic [3:0] pre_cnt_q;
  logic [2:0] ref_left_q;
  logic [7:0] ref_cnt_q;
  logic [7:0] div_q;
  logic ref_pend_q;
  logic [2:0] burst_n;
  // Burst count code maps to 1,2,4,6,8 refreshes
  assign burst_n = refresh_burst_in == 3'h0 ? 3'h0 :
    refresh_burst_in == 3'h1 ? 3'h1 :
    refresh_burst_in == 3'h2 ? 3'h3 :
    refresh_burst_in == 3'h3 ? 3'h5 : 3'h7;
  logic div_tick, match;
  assign div_tick = div_q == 8'(REFRESH_DIV - 1);
  assign match = div_tick && ref_cnt_q == refresh_const_in;

  logic access_done;
  assign access_done = state_q == ST_END;
  logic last_beat;
  assign last_beat = !fill_q || beat_q == 2'(bus_state_pkg::LINE_WORDS - 1);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (release_act)
          state_d = ST_RELEASED;
        else if (ref_pend_q && !self_refresh_in)
          state_d = ST_REFRESH;
        // Valid still stands in the ack cycle, so a second take waits
        else if (cpu_req_in.valid && space_ok && !self_refresh_in &&
          !cpu_ack_out)
          state_d = ST_ADDR;
      ST_ADDR:
        state_d = ST_WAIT;
      ST_WAIT:
        if (wait_cnt_q == 4'h0 && !wait_act)
          state_d = ST_END;
      ST_END:
        if (!last_beat)
          state_d = ST_ADDR;
        else if (is_dram || is_sdram)
          state_d = ST_PRECHARGE;
        else
          state_d = ST_IDLE;
      ST_PRECHARGE:
        if (pre_cnt_q == 4'h0)
          state_d = ST_IDLE;
      ST_REFRESH:
        if (ref_left_q == 3'h0)
          state_d = ST_IDLE;
      ST_RELEASED:
        if (!release_act)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      wait_sync_q <= 3'h7;
      rel_sync_q <= 3'h0;
    end
    else
    begin
      wait_sync_q <= {wait_sync_q[1:0], wait_n_in};
      rel_sync_q <= {rel_sync_q[1:0], release_request_in};
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ST_IDLE;
      req_q <= '0;
      space_q <= 3'h0;
      fill_q <= 1'b0;
      beat_q <= 2'h0;
      wait_cnt_q <= 4'h0;
      pre_cnt_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE && state_d == ST_ADDR)
      begin
        req_q <= cpu_req_in;
        req_q.cached <= !through_w;
        space_q <= space_w;
        fill_q <= !through_w && !cpu_req_in.write;
        beat_q <= 2'h0;
      end
      else if (state_q == ST_END && !last_beat)
        beat_q <= beat_q + 2'h1;
      if (state_d == ST_ADDR)
        wait_cnt_q <= cfg_q[state_q == ST_IDLE ? space_w : space_q].waits;
      else if (state_q == ST_WAIT && wait_cnt_q != 4'h0)
        wait_cnt_q <= wait_cnt_q - 4'h1;
      if (state_d == ST_PRECHARGE && state_q != ST_PRECHARGE)
        pre_cnt_q <= 4'(bus_state_pkg::PRECHARGE_CYC - 1);
      else if (pre_cnt_q != 4'h0)
        pre_cnt_q <= pre_cnt_q - 4'h1;
    end
  end

  // Refresh interval timer, also usable as a plain timer
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      div_q <= 8'h00;
      ref_cnt_q <= 8'h00;
      ref_pend_q <= 1'b0;
      ref_left_q <= 3'h0;
      compare_match_irq_out <= 1'b0;
    end
    else
    begin
      div_q <= div_tick ? 8'h00 : div_q + 8'h01;
      if (match)
        ref_cnt_q <= 8'h00;
      else if (div_tick)
        ref_cnt_q <= ref_cnt_q + 8'h01;
      compare_match_irq_out <= match;
      if (match)
        ref_pend_q <= 1'b1;
      else if (state_q == ST_IDLE && state_d == ST_REFRESH)
        ref_pend_q <= 1'b0;
      if (state_q == ST_IDLE && state_d == ST_REFRESH)
        ref_left_q <= burst_n;
      else if (state_q == ST_REFRESH && ref_left_q != 3'h0)
        ref_left_q <= ref_left_q - 3'h1;
    end
  end

  // Lane placement of write data and byte strobes
  logic [1:0] lane;
  assign lane = req_q.addr[1:0];
  logic [31:0] wlane;
  logic [3:0] strobe;
  assign wlane = cur_cfg.width == bus_state_pkg::WIDTH_8 ?
      {24'h000000, req_q.wdata[7:0]} :
    cur_cfg.width == bus_state_pkg::WIDTH_16 ?
      {16'h0000, req_q.wdata[15:0]} :
    req_q.size == bus_state_pkg::SIZE_BYTE ?
      req_q.wdata << {lane, 3'b000} : req_q.wdata;
  assign strobe = cur_cfg.width == bus_state_pkg::WIDTH_8 ? 4'h1 :
    cur_cfg.width == bus_state_pkg::WIDTH_16 ? 4'h3 :
    req_q.size == bus_state_pkg::SIZE_BYTE ? 4'(4'h1 << lane) :
    req_q.size == bus_state_pkg::SIZE_WORD ? (lane[1] ? 4'hC : 4'h3) : 4'hF;

  logic [24:0] ext_addr;
  // DRAM types see row then column on the same pins
  assign ext_addr = (is_dram || is_sdram) && state_q != ST_ADDR ?
    {12'h000, req_q.addr[14:2]} :
    {req_q.addr[24:4], (fill_q ? beat_q : req_q.addr[3:2]),
     req_q.addr[1:0]};
  logic active;
  assign active = state_q == ST_ADDR || state_q == ST_WAIT ||
    state_q == ST_END;
  logic sel_hide;
  assign sel_hide = space_q == 3'(bus_state_pkg::DRAM_SPACE) && is_dram;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      ext_bus_out <= '1;
      ext_bus_out.addr <= '0;
      ext_bus_out.data <= '0;
      ext_bus_out.rd_wr <= 1'b1;
      byte_strobe_n_out <= 4'hF;
      grant_out <= 1'b0;
      cke_out <= 1'b1;
      cpu_ack_out <= 1'b0;
      cpu_rdata_out <= 32'h00000000;
      cfg_rdata_out <= 32'h00000000;
      write_buffer_dirty_out <= 1'b0;
    end
    else
    begin
      ext_bus_out.addr <= ext_addr;
      ext_bus_out.data <= wlane;
      ext_bus_out.data_oe_n <= !(active && req_q.write);
      // Taken from the current state so it stands with the address
      ext_bus_out.start_n <= !(state_q == ST_ADDR && !is_dram &&
        !is_sdram);
      for (int i = 0; i < SPACE_N; i++)
        ext_bus_out.sel_n[i] <= !(active && space_q == 3'(i) &&
          !(i == bus_state_pkg::DRAM_SPACE && sel_hide));
      ext_bus_out.rd_wr <= !(active && req_q.write);
      ext_bus_out.rd_n <= !(active && !req_q.write);
      ext_bus_out.ras_n <= !((active && (is_dram || is_sdram)) ||
        state_q == ST_REFRESH);
      ext_bus_out.cas_n <= !((state_q == ST_WAIT && (is_dram || is_sdram)) ||
        state_q == ST_REFRESH);
      ext_bus_out.bus_oe_n <= state_d == ST_RELEASED;
      byte_strobe_n_out <= active && req_q.write ? ~strobe : 4'hF;
      grant_out <= state_d == ST_RELEASED;
      cke_out <= !(self_refresh_in && state_q == ST_IDLE);
      cpu_ack_out <= state_q == ST_END && last_beat;
      if (state_q == ST_END)
        cpu_rdata_out <= external_data_in;
      cfg_rdata_out <= {16'h0000, cfg_rd};
      if (state_q == ST_END && req_q.write && req_q.cached)
        write_buffer_dirty_out <= write_back_in;
    end
  end
endmodule : bus_state_unit

// [bus_state_unit_assertions.sv]
// Port checks for the bus state unit
`timescale 1ns/1ns
module bus_state_unit_assertions (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire bus_state_pkg::cpu_req_t cpu_req_in,
  input wire logic cpu_ack_out,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic release_request_in,
  input wire logic grant_out,
  input wire bus_state_pkg::ext_bus_t ext_bus_out,
  input wire logic cke_out,
  input wire logic compare_match_irq_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire logic idle_sel = &ext_bus_out.sel_n;
  property p_start_one;
    !ext_bus_out.start_n && !idle_sel |=> ext_bus_out.start_n;
  endproperty
  a_start_one: assert property (p_start_one)
    else $error("start strobe longer than one cycle");
  property p_one_sel;
    $onehot0(~ext_bus_out.sel_n);
  endproperty
  a_one_sel: assert property (p_one_sel)
    else $error("two spaces selected");
  property p_float;
    grant_out |-> ext_bus_out.bus_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("bus driven while granted");
  property p_hold;
    grant_out && release_request_in |=> grant_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("grant dropped under request");
  property p_late;
    $rose(grant_out) |-> idle_sel && $past(idle_sel);
  endproperty
  a_late: assert property (p_late)
    else $error("grant during access");
  property p_upper;
    cfg_rdata_out[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper)
    else $error("config upper half not zero");
  property p_cke;
    !cke_out |-> idle_sel;
  endproperty
  a_cke: assert property (p_cke)
    else $error("access while clock enable low");
  property p_dir;
    !ext_bus_out.rd_n |-> ext_bus_out.rd_wr;
  endproperty
  a_dir: assert property (p_dir)
    else $error("read pulse in write cycle");
  property p_ack;
    $rose(cpu_req_in.valid) && cke_out && !grant_out
      && cpu_req_in.addr[27:25] < 3'h5 |-> ##[1:400] cpu_ack_out;
  endproperty
  a_ack: assert property (p_ack)
    else $error("access never completed");
  c_ack: cover property (cpu_ack_out);
  c_grant: cover property ($rose(grant_out));
  c_irq: cover property (compare_match_irq_out);
endmodule : bus_state_unit_assertions

bind bus_state_unit bus_state_unit_assertions i_chk (.sys_clk_in,
  .rst_n_in, .cpu_req_in, .cpu_ack_out, .cfg_rdata_out,
  .release_request_in, .grant_out, .ext_bus_out, .cke_out,
  .compare_match_irq_out);

// [ext_mem_model.sv]
// External memory that answers reads and can stall with wait
`timescale 1ns/1ns
module ext_mem_model #(
  parameter logic [31:0] WORD = 32'h5AC3_1E87
) (
  input wire logic sys_clk_in,
  input wire bus_state_pkg::ext_bus_t bus_in,
  input wire logic [3:0] extra_waits_in,
  output logic [31:0] data_out,
  output logic wait_n_out
);
  logic [3:0] cnt_q = 4'h0;
  logic [31:0] last_q = 32'h0000_0000;
  // Off the read pulse the lines flip every cycle, so stale data shows
  assign data_out = !bus_in.rd_n ? WORD : ~last_q;
  // Wait drops with the strobe so the three-stage pin filter sees it in time
  assign wait_n_out = cnt_q == 4'h0 &&
    (bus_in.start_n || extra_waits_in == 4'h0);
  always @(posedge sys_clk_in)
  begin
    last_q <= data_out;
    if (!bus_in.start_n)
      cnt_q <= extra_waits_in;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule : ext_mem_model

// [bus_state_unit_tb.sv]
// Self-checking bench for the bus state unit
`timescale 1ns/1ns
module bus_state_unit_tb;
  typedef struct packed {
    logic [31:0] a;
    logic w;
    bus_state_pkg::size_t sz;
    logic [2:0] ns;
    logic [3:0] bs;
  } row_t;
  localparam logic [31:0] WORD = 32'h5AC3_1E87;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  bus_state_pkg::cpu_req_t req = '0;
  logic cfg_wr = 1'b0, cfg_long = 1'b0, srf = 1'b0, rel = 1'b0, wb = 1'b0;
  logic [2:0] cfg_idx = 3'h0, rb = 3'h0;
  logic [31:0] cfg_wd = 32'h0, rdata, cfg_rd, ext_d, dseen, aseen;
  logic [3:0] xw = 4'h0, bs_n, bs_seen;
  logic ack, dirty, irq, wait_n, grant, cke, sel3, ras;
  bus_state_pkg::ext_bus_t bus;
  row_t rows [10];
  int mismatches = 0, n_compared = 0, lat, starts, lat0, n_cas;
  always #20 sys_clk_in = ~sys_clk_in;
  bus_state_unit #(.REFRESH_DIV(2)) i_dut (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .cpu_req_in(req), .cpu_ack_out(ack),
    .cpu_rdata_out(rdata), .cfg_wr_in(cfg_wr), .cfg_idx_in(cfg_idx),
    .cfg_wdata_in(cfg_wd), .cfg_long_in(cfg_long), .cfg_rdata_out(cfg_rd),
    .write_back_in(wb), .write_buffer_dirty_out(dirty),
    .self_refresh_in(srf), .refresh_burst_in(rb),
    .refresh_const_in(8'h20), .compare_match_irq_out(irq),
    .external_data_in(ext_d), .wait_n_in(wait_n),
    .release_request_in(rel), .grant_out(grant), .ext_bus_out(bus),
    .cke_out(cke), .byte_strobe_n_out(bs_n));
  ext_mem_model #(.WORD(WORD)) i_mem (.sys_clk_in(sys_clk_in),
    .bus_in(bus), .extra_waits_in(xw), .data_out(ext_d),
    .wait_n_out(wait_n));
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wt(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    while (s !== v && n < 3000)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    chk(nm, 32'(v), 32'(s));
    if (n == 3000)
      report_and_stop();
  endtask : wt
  // Valid is held until ack, as the handshake requires
  task automatic acc(input row_t r, input logic [31:0] d);
    @(posedge sys_clk_in);
    req <= '{1'b1, r.w, r.a, r.sz, d, 1'b0};
    lat = 0; starts = 0; bs_seen = 4'hF; sel3 = 0; ras = 0;
    do
    begin
      @(posedge sys_clk_in);
      lat++;
      starts += int'(!bus.start_n);
      bs_seen = bs_seen & bs_n;
      sel3 |= !bus.sel_n[3];
      ras |= !bus.ras_n;
      if (!bus.data_oe_n)
        dseen = bus.data;
      if (!bus.start_n)
        aseen = 32'(bus.addr);
    end while (ack !== 1'b1 && lat < 400);
    req.valid <= 1'b0;
    wt(ack, 1'b1, "ack");
  endtask : acc
  task automatic cfgw(input logic [2:0] i, input logic [31:0] d);
    @(posedge sys_clk_in);
    cfg_idx <= i; cfg_wd <= d; cfg_long <= 1'b1; cfg_wr <= 1'b1;
    @(posedge sys_clk_in);
    cfg_wr <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask : cfgw
  initial
  begin
    for (int k = 0; k < 5; k++)
      rows[k] = '{32'h2000_0000 | (k << 25), 1'b0,
        bus_state_pkg::SIZE_LONG, 3'h1, 4'hF};
    for (int k = 0; k < 4; k++)
      rows[5+k] = '{32'h2200_0000 + k, 1'b1,
        bus_state_pkg::SIZE_BYTE, 3'h1, ~(4'h1 << k)};
    rows[9] = '{32'h0000_0010, 1'b0, bus_state_pkg::SIZE_LONG, 3'h4, 4'hF};
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    chk("grant", 0, grant);
    chk("cke", 1, cke);
    chk("cfg", 32'h0000_0308, cfg_rd);
    $display("reset test done");
    for (int i = 0; i < 10; i++)
    begin
      rb <= 3'(i % 5);
      wb <= i[0];
      acc(rows[i], 32'hA5A5_A5A5);
      chk("starts", rows[i].ns, starts);
      if (rows[i].ns == 3'h1)
        chk("addr", 32'(rows[i].a[24:0]), aseen);
      if (rows[i].w)
        chk("lanes", rows[i].bs, bs_seen);
      else
        chk("rdata", WORD, rdata);
      $display("row %0d done", i);
    end
    lat0 = lat;
    wb <= 1'b1;
    acc('{32'h0200_0000, 1'b1, bus_state_pkg::SIZE_LONG, 3'h1, 4'h0},
      32'h0F0F_0F0F);
    chk("dirty", 1, dirty);
    chk("lanes", 4'h0, bs_seen);
    wb <= 1'b0;
    acc('{32'h0200_0004, 1'b1, bus_state_pkg::SIZE_LONG, 3'h1, 4'h0},
      32'hF0F0_F0F0);
    chk("clean", 0, dirty);
    $display("write mode test done");
    xw <= 4'h6;
    acc(rows[9], 32'h0);
    xw <= 4'h0;
    chk("wait", 1, lat > lat0);
    chk("fill addr", 32'h0000_001C, aseen);
    $display("wait test done");
    cfgw(3'h4, 32'hA55A_0004);
    chk("cfg", 32'h0000_0004, cfg_rd);
    cfgw(3'h4, 32'h0000_0308);
    chk("cfg key", 32'h0000_0004, cfg_rd);
    acc('{32'h2800_0000, 1'b1, bus_state_pkg::SIZE_WORD, 3'h1, 4'hF},
      32'h5678_1234);
    chk("low data", 32'h1234, dseen[15:0]);
    chk("high lanes", 2'b11, bs_seen[3:2]);
    $display("width test done");
    cfgw(3'h3, 32'hA55A_0018);
    acc('{32'h2600_0000, 1'b0, bus_state_pkg::SIZE_LONG, 3'h1, 4'hF}, 0);
    chk("dram select", 0, sel3);
    chk("row strobe", 1, ras);
    $display("dram test done");
    srf <= 1'b1;
    wt(cke, 1'b0, "self refresh");
    srf <= 1'b0;
    wt(cke, 1'b1, "cke back");
    $display("self refresh test done");
    rel <= 1'b1;
    wt(grant, 1'b1, "grant");
    chk("float", 1, bus.bus_oe_n);
    rel <= 1'b0;
    wt(grant, 1'b0, "grant end");
    $display("release test done");
    rb <= 3'h4;
    wt(irq, 1'b1, "irq");
    n_cas = 0;
    repeat (20)
    begin
      @(posedge sys_clk_in);
      n_cas += int'(!bus.cas_n && !bus.ras_n);
    end
    chk("refresh burst", 8, n_cas);
    $display("timer test done");
    report_and_stop();
  end
endmodule : bus_state_unit_tb
